// >>> design/mcsc_top.sv
// Multi-chip sync control: serial register port, data clock and sync paths
// Notes on behaviour
// - Data timing error checks run only on request when the mode bit is 0 and on every sample when 1; sync input checks run on every sample.
// - Data clock divide codes 00 and 11 give 1, 01 gives 2, and 10 gives 4.
// - The data timing error flag sets only when measured margin is below the programmed margin.
// - The data clock output is delayed from the reference clock by the four low delay bits.
// - Sync output runs at DAC rate over N with codes 0 to 5 giving 32 down to 1; 6 and 7 unused.
// - Sync output is delayed by a five-bit code, one step per count, zero meaning nominal.
// - An internal sync pulse is made only after the programmed number plus one sync input pulses.
// - The sync input passes a five-bit programmable delay line before use.
// - The sync input is accepted only while its enable bit is 1, which resets to 0.
// - The sync output is driven only while its enable bit is 1, which resets to 0.
// - Sync output launches on the reference falling edge with edge bit 0, rising edge with 1.
// - On synchronization the clock generation state loads the programmed clock state.
// - The data clock delay applies only while the delay enable bit is set.
// - A fifth delay bit in the digital control register extends the data clock delay code.
`timescale 1ns/1ns
`default_nettype none

module mcsc_delay_line (
  input wire logic clk_i, // Sample clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic in_i, // Signal to delay
  input wire logic [4:0] code_i, // Extra taps
  output logic out_o // Delayed signal
);
  import mcsc_pkg::*;
  logic [DLY_TAPS-1:0] taps_q;
  // Tap chain; the selected tap is registered so the output is glitch free
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      taps_q <= '0;
      out_o <= 1'b0;
    end else begin
      taps_q <= {taps_q[DLY_TAPS-2:0], in_i};
      out_o <= (code_i == 5'h00) ? in_i : taps_q[code_i - 5'h01];
    end
  end
  property p_dly_zero;
    @(posedge clk_i) disable iff (!rst_b_i)
    (code_i == 5'h00) |=> (out_o == $past(in_i));
  endproperty
  a_dly_zero: assert property (p_dly_zero) else $error("zero delay code not nominal");
endmodule

module mcsc_top (
  input wire logic clk_i, // DAC sample clock, 100 MHz
  input wire logic rst_b_i, // Async reset, active low
  input wire logic sclk_i, // Serial port clock pin
  input wire logic cs_b_i, // Serial port select pin, active low
  input wire logic sdio_i, // Serial data pin in
  output logic sdio_o, // Serial data pin out
  output logic sdio_oe_o, // Serial data drive enable
  input wire logic reference_clock_input_i, // Reference clock pin
  input wire logic sync_in_i, // Sync input pin from peer
  input wire logic [3:0] meas_margin_i, // Measured data timing margin
  input wire logic meas_valid_i, // Data margin sample strobe
  input wire logic manual_check_i, // Manual check request
  input wire logic [3:0] si_meas_margin_i, // Measured sync input margin
  input wire logic si_meas_valid_i, // Sync margin sample strobe
  output logic data_clock_output_o, // Divided, delayed data clock
  output logic sync_out_o, // Sync output to peers
  output logic sync_pulse_o, // Internal sync pulse
  output logic [4:0] clk_state_o, // Clock generation state
  output logic data_timing_err_o, // Sticky data timing error
  output logic sync_timing_err_o // Sticky sync input timing error
);
  import mcsc_pkg::*;

  // Pin synchronisers; only the second stage and later are read by logic
  logic [2:0] sclk_s_q, cs_s_q, ref_s_q;
  logic [1:0] sdi_s_q, si_s_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_s_q <= '0;
      cs_s_q <= 3'h7;
      ref_s_q <= '0;
      sdi_s_q <= '0;
      si_s_q <= '0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk_i};
      cs_s_q <= {cs_s_q[1:0], cs_b_i};
      ref_s_q <= {ref_s_q[1:0], reference_clock_input_i};
      sdi_s_q <= {sdi_s_q[0], sdio_i};
      si_s_q <= {si_s_q[0], sync_in_i};
    end
  end
  wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
  wire cs_act = ~cs_s_q[1];
  wire ref_rise = ref_s_q[1] & ~ref_s_q[2];
  wire ref_fall = ~ref_s_q[1] & ref_s_q[2];

  // Register storage
  logic dly_msb_q, dly_en_q;
  mcsc_cfg_t cfg_q;
  mcsc_ddly_t ddly_q;
  mcsc_sodly_t sodly_q;
  mcsc_sidly_t sidly_q;
  mcsc_sen_t sen_q;

  // Serial frame state: bit counter, instruction and shift registers
  logic [3:0] bit_q;
  logic [7:0] instr_q, shin_q, shout_q;
  logic rd_q;
  wire [7:0] shin_nx = {shin_q[6:0], sdi_s_q[1]};
  wire instr_done = cs_act & sclk_rise & (bit_q == INSTR_LAST);
  wire wr_done = cs_act & sclk_rise & (bit_q == FRAME_LAST) & ~instr_q[RD_BIT];
  wire [4:0] addr = instr_done ? shin_nx[4:0] : instr_q[4:0];

  // Read mux; unmapped addresses and foreign bits read as zero
  logic [7:0] rd_data;
  always_comb begin
    rd_data = 8'h00;
    unique case (addr)
      ADDR_DIGCTL_A: rd_data[DCLK_DLY_MSB_BIT] = dly_msb_q;
      ADDR_DIGCTL_B: rd_data[DCLK_DLY_EN_BIT] = dly_en_q;
      ADDR_CFG: rd_data = cfg_q;
      ADDR_DDLY: rd_data = ddly_q;
      ADDR_SODLY: rd_data = sodly_q;
      ADDR_SIDLY: rd_data = sidly_q;
      ADDR_SEN: rd_data = sen_q;
      default: rd_data = 8'h00;
    endcase
  end

  // Serial slave: MSB first, data changes on the falling serial clock edge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_q <= '0;
      instr_q <= '0;
      shin_q <= '0;
      shout_q <= '0;
      rd_q <= 1'b0;
      sdio_o <= 1'b0;
      sdio_oe_o <= 1'b0;
    end else if (!cs_act) begin
      bit_q <= '0;
      rd_q <= 1'b0;
      sdio_oe_o <= 1'b0;
    end else begin
      if (sclk_rise) begin
        shin_q <= shin_nx;
        bit_q <= bit_q + 4'h1;
      end
      if (instr_done) begin
        instr_q <= shin_nx;
        shout_q <= rd_data;
        rd_q <= shin_nx[RD_BIT];
      end
      if (sclk_fall && rd_q) begin
        sdio_o <= shout_q[7];
        sdio_oe_o <= 1'b1;
        shout_q <= {shout_q[6:0], 1'b0};
      end
    end
  end

  // Register writes at the last data bit; the reserved bit stores as written
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dly_msb_q <= 1'b0;
      dly_en_q <= 1'b0;
      cfg_q <= REG_RST;
      ddly_q <= REG_RST;
      sodly_q <= REG_RST;
      sidly_q <= REG_RST;
      sen_q <= REG_RST;
    end else if (wr_done) begin
      unique case (addr)
        ADDR_DIGCTL_A: dly_msb_q <= shin_nx[DCLK_DLY_MSB_BIT];
        ADDR_DIGCTL_B: dly_en_q <= shin_nx[DCLK_DLY_EN_BIT];
        ADDR_CFG: cfg_q <= shin_nx;
        ADDR_DDLY: ddly_q <= shin_nx;
        ADDR_SODLY: sodly_q <= shin_nx;
        ADDR_SIDLY: sidly_q <= shin_nx;
        ADDR_SEN: sen_q <= shin_nx;
        default: ;
      endcase
    end
  end

  // Timing checks: data check in manual mode only on request, auto on every sample; sync check on every sample
  wire chk = meas_valid_i & (cfg_q.auto_mode | manual_check_i);
  wire dt_set = chk & (meas_margin_i < cfg_q.data_margin);
  wire st_set = si_meas_valid_i & (si_meas_margin_i < sidly_q.si_margin);
  wire dt_clr = wr_done & (addr == ADDR_CFG);
  wire st_clr = wr_done & (addr == ADDR_SIDLY);
  // Flags clear on a write to their own register; a set in that cycle wins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_timing_err_o <= 1'b0;
      sync_timing_err_o <= 1'b0;
    end else begin
      data_timing_err_o <= dt_set | (data_timing_err_o & ~dt_clr);
      sync_timing_err_o <= st_set | (sync_timing_err_o & ~st_clr);
    end
  end

  // Data clock divider counts reference rising edges
  logic [1:0] dcnt_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) dcnt_q <= '0;
    else if (ref_rise) dcnt_q <= dcnt_q + 2'h1;
  end
  wire div2 = cfg_q.dclk_div == DIV_BY2;
  wire div4 = cfg_q.dclk_div == DIV_BY4;
  wire dclk_raw = div4 ? dcnt_q[1] : (div2 ? dcnt_q[0] : ref_s_q[2]);
  wire [4:0] dclk_code = dly_en_q ? {dly_msb_q, ddly_q.dclk_dly} : 5'h00;
  logic dclk_dly;
  mcsc_delay_line u_dclk_dly (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_i(dclk_raw),
    .code_i(dclk_code),
    .out_o(dclk_dly)
  );

  // Sync output: tick every N DAC cycles, launched on the chosen reference edge
  logic [4:0] so_cnt_q;
  logic so_pend_q, so_lvl_q;
  wire [4:0] so_nm1 = SO_CNT_MAX >> ddly_q.so_div;
  wire so_tick = so_cnt_q >= so_nm1;
  wire so_edge = sen_q.so_rise_edge ? ref_rise : ref_fall;
  wire so_launch = so_pend_q & so_edge;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      so_cnt_q <= '0;
      so_pend_q <= 1'b0;
      so_lvl_q <= 1'b0;
    end else begin
      so_cnt_q <= so_tick ? 5'h00 : so_cnt_q + 5'h01;
      so_pend_q <= so_tick | (so_pend_q & ~so_launch);
      so_lvl_q <= so_launch;
    end
  end
  logic so_dly;
  mcsc_delay_line u_so_dly (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_i(so_lvl_q),
    .code_i({ddly_q.so_dly_msb, sodly_q.so_dly}),
    .out_o(so_dly)
  );

  // Sync input: delayed, edge counted while enabled, pulse after ratio+1 edges
  logic si_dly, si_dly_q;
  mcsc_delay_line u_si_dly (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_i(si_s_q[1]),
    .code_i({sodly_q.si_dly_msb, sidly_q.si_dly}),
    .out_o(si_dly)
  );
  logic [2:0] si_cnt_q;
  wire si_rise = sen_q.si_en & si_dly & ~si_dly_q;
  wire sync_gen = si_rise & (si_cnt_q == sodly_q.si_ratio);
  // Clock generation state advances freely and is loaded on synchronization
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      si_dly_q <= 1'b0;
      si_cnt_q <= '0;
      sync_pulse_o <= 1'b0;
      clk_state_o <= '0;
    end else begin
      si_dly_q <= si_dly;
      if (sync_gen) si_cnt_q <= '0;
      else if (si_rise) si_cnt_q <= si_cnt_q + 3'h1;
      sync_pulse_o <= sync_gen;
      clk_state_o <= sync_gen ? sen_q.clk_state : clk_state_o + 5'h01;
    end
  end

  // Output flops; the enable gates after the delay so disabling is immediate
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_clock_output_o <= 1'b0;
      sync_out_o <= 1'b0;
    end else begin
      data_clock_output_o <= dclk_dly;
      sync_out_o <= sen_q.so_en & so_dly;
    end
  end

  property p_so_off;
    @(posedge clk_i) disable iff (!rst_b_i) !sen_q.so_en |=> !sync_out_o;
  endproperty
  a_so_off: assert property (p_so_off) else $error("sync out while disabled");
  property p_si_off;
    @(posedge clk_i) disable iff (!rst_b_i) !sen_q.si_en |=> !sync_pulse_o;
  endproperty
  a_si_off: assert property (p_si_off) else $error("sync pulse while input off");
  property p_state_load;
    @(posedge clk_i) disable iff (!rst_b_i)
    sync_pulse_o |-> clk_state_o == $past(sen_q.clk_state);
  endproperty
  a_state_load: assert property (p_state_load) else $error("clock state not loaded");
  property p_dt_margin;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(data_timing_err_o) |-> $past(meas_margin_i < cfg_q.data_margin);
  endproperty
  a_dt_margin: assert property (p_dt_margin) else $error("error set without short margin");
  property p_dt_mode;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(data_timing_err_o) |-> $past(cfg_q.auto_mode || manual_check_i);
  endproperty
  a_dt_mode: assert property (p_dt_mode) else $error("manual mode checked unasked");
  property p_st_margin;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(sync_timing_err_o) |-> $past(si_meas_margin_i < sidly_q.si_margin);
  endproperty
  a_st_margin: assert property (p_st_margin) else $error("sync error without short margin");
  property p_n1;
    @(posedge clk_i) disable iff (!rst_b_i) (ddly_q.so_div == 3'h5) |=> so_pend_q;
  endproperty
  a_n1: assert property (p_n1) else $error("divide by one missed a tick");
  property p_edge;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(so_lvl_q) |-> $past(sen_q.so_rise_edge ? ref_rise : ref_fall);
  endproperty
  a_edge: assert property (p_edge) else $error("sync out on wrong edge");
  property p_ratio;
    @(posedge clk_i) disable iff (!rst_b_i)
    sync_pulse_o |-> $past(si_cnt_q == sodly_q.si_ratio && si_rise);
  endproperty
  a_ratio: assert property (p_ratio) else $error("sync pulse before ratio met");
endmodule

`default_nettype wire

// >>> design/mcsc_pkg.sv
// Package of register map, field layouts and timing constants for the sync control block
package mcsc_pkg;
  // Register addresses on the serial port
  localparam logic [4:0] ADDR_DIGCTL_A = 5'h01;
  localparam logic [4:0] ADDR_DIGCTL_B = 5'h02;
  localparam logic [4:0] ADDR_CFG = 5'h03;
  localparam logic [4:0] ADDR_DDLY = 5'h04;
  localparam logic [4:0] ADDR_SODLY = 5'h05;
  localparam logic [4:0] ADDR_SIDLY = 5'h06;
  localparam logic [4:0] ADDR_SEN = 5'h07;
  localparam logic [7:0] REG_RST = 8'h00;
  // Field positions inside the two shared digital control registers
  localparam int DCLK_DLY_MSB_BIT = 1;
  localparam int DCLK_DLY_EN_BIT = 4;
  // Serial frame: instruction byte then one data byte, read flag in bit 7
  localparam logic [3:0] FRAME_LAST = 4'hF;
  localparam logic [3:0] INSTR_LAST = 4'h7;
  localparam int RD_BIT = 7;
  // Data clock divider codes
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;
  // Sync output divider: N-1 is the longest count shifted right by the code
  localparam logic [4:0] SO_CNT_MAX = 5'h1F;
  // Delay lines: one tap per clock models one step of the analogue line
  localparam int STEP_PS = 80;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int TAP_CYCLES = (STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DLY_TAPS = 32;
  typedef struct packed {
    logic auto_mode;
    logic rsvd_one;
    logic [1:0] dclk_div;
    logic [3:0] data_margin;
  } mcsc_cfg_t;
  typedef struct packed {
    logic [3:0] dclk_dly;
    logic [2:0] so_div;
    logic so_dly_msb;
  } mcsc_ddly_t;
  typedef struct packed {
    logic [3:0] so_dly;
    logic [2:0] si_ratio;
    logic si_dly_msb;
  } mcsc_sodly_t;
  typedef struct packed {
    logic [3:0] si_dly;
    logic [3:0] si_margin;
  } mcsc_sidly_t;
  typedef struct packed {
    logic si_en;
    logic so_en;
    logic so_rise_edge;
    logic [4:0] clk_state;
  } mcsc_sen_t;
endpackage

// >>> verif/mcsc_peer.sv
// Peer converter model: reference clock source, sync pulse sender, sync output counter
`timescale 1ns/1ns
`default_nettype none

module mcsc_peer (
  input wire logic clk_i, // Sample clock used to time pulses
  input wire logic sync_out_i, // Sync output of the device under test
  output logic ref_clk_o, // Reference clock, 20 sample clocks a period
  output logic sync_o // Sync pulse towards the device
);
  logic [7:0] so_cnt;
  // Reference clock runs free; unrelated edges keep the sampler honest
  initial begin
    ref_clk_o = 1'b0;
    sync_o = 1'b0;
    so_cnt = 8'h00;
    #3;
    forever #100 ref_clk_o = ~ref_clk_o;
  end
  // Count launched sync output pulses, one per high cycle
  always @(posedge clk_i) begin
    if (sync_out_i) so_cnt <= so_cnt + 8'h01;
  end
  // Pulses stay wide enough for the two-flop synchroniser
  task automatic send(input int n);
    repeat (n) begin
      @(posedge clk_i); #1 sync_o = 1'b1;
      repeat (4) @(posedge clk_i);
      #1 sync_o = 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
endmodule

`default_nettype wire

// >>> verif/multichip_sync_control_test.sv
// Self-checking bench for the sync control block over its serial port
`timescale 1ns/1ns
`default_nettype none

module multichip_sync_control_test;
  import mcsc_pkg::*;
  logic clk_i, rst_b_i, sclk, cs_b, m_drv, meas_valid, manual, si_valid, ref_clk, sync_in;
  logic sdio_o, sdio_oe, dclk, sync_out, sync_pulse, dterr, sterr, dclk_q;
  logic [3:0] meas, si_meas;
  logic [4:0] clk_state, st_cap;
  logic [7:0] sp_cnt, dc_cnt, v;
  logic [7:0] div_exp [4] = '{8'h14, 8'h0A, 8'h05, 8'h14};
  wire sdio_w = sdio_oe ? sdio_o : m_drv;
  int miscompares, n_tests, cyc;

  mcsc_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_b_i(cs_b),
    .sdio_i(sdio_w), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe), .reference_clock_input_i(ref_clk),
    .sync_in_i(sync_in), .meas_margin_i(meas), .meas_valid_i(meas_valid),
    .manual_check_i(manual), .si_meas_margin_i(si_meas), .si_meas_valid_i(si_valid),
    .data_clock_output_o(dclk), .sync_out_o(sync_out), .sync_pulse_o(sync_pulse),
    .clk_state_o(clk_state), .data_timing_err_o(dterr), .sync_timing_err_o(sterr));
  mcsc_peer u_peer (.clk_i(clk_i), .sync_out_i(sync_out), .ref_clk_o(ref_clk), .sync_o(sync_in));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Edge counters and capture of the clock state on each sync pulse
  always @(posedge clk_i) begin
    dclk_q <= dclk;
    cyc <= cyc + 1;
    if (dclk && !dclk_q) dc_cnt <= dc_cnt + 8'h01;
    if (sync_pulse) begin
      sp_cnt <= sp_cnt + 8'h01;
      st_cap <= clk_state;
    end
    if (cyc == 40000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Counts off by one at the window edges are accepted
  function automatic logic [7:0] near(input logic [7:0] c, input logic [7:0] e);
    return (c + 8'h01 >= e && c <= e + 8'h01) ? e : c;
  endfunction
  // One 16-bit frame; phases of 6 clocks clear the synchroniser and read latency
  task automatic xfer(input logic [7:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] f;
    f = {ins, wd};
    rd = 8'h00;
    cs_b = 1'b0;
    tick(6);
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      m_drv = f[i];
      tick(6);
      if (i < 8) rd[i] = sdio_w;
      sclk = 1'b1;
      tick(6);
    end
    sclk = 1'b0;
    tick(6);
    cs_b = 1'b1;
    tick(6);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] x;
    xfer({3'h0, a}, d, x);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] x;
    xfer({3'h4, a}, 8'h55, x);
    check("register", x, e);
  endtask
  task automatic margin(input logic [3:0] m, input logic man, input logic [3:0] s);
    meas = m;
    manual = man;
    si_meas = s;
    meas_valid = 1'b1;
    si_valid = 1'b1;
    tick(1);
    meas_valid = 1'b0;
    si_valid = 1'b0;
    tick(2);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {sclk, m_drv, meas_valid, manual, si_valid, dclk_q} = 6'h00;
    {cs_b, meas, si_meas} = 9'h100;
    {sp_cnt, dc_cnt, st_cap, miscompares, n_tests, cyc} = '0;
    rst_b_i = 1'b0;
    tick(2);
    rst_b_i = 1'b1;
    tick(4);
    // Reset values, enables off, unmapped place reads zero
    for (int a = 3; a < 8; a++) rd(a[4:0], REG_RST);
    rd(5'h1F, 8'h00);
    $display("reset test done");
    // Access of every register except ADDR_SEN and ADDR_DIGCTL_B; reserved bit written as 1
    wr(ADDR_CFG, 8'h40);
    wr(ADDR_DDLY, 8'hA8);
    wr(ADDR_SODLY, 8'h5A);
    wr(ADDR_SIDLY, 8'h93);
    wr(ADDR_DIGCTL_A, 8'hFF);
    rd(ADDR_CFG, 8'h40);
    rd(ADDR_DDLY, 8'hA8);
    rd(ADDR_SODLY, 8'h5A);
    rd(ADDR_SIDLY, 8'h93);
    rd(ADDR_DIGCTL_A, 8'h02);
    $display("register test done");
    // Data clock divider over 400 clocks, 20 reference periods
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CFG, {2'h1, c[1:0], 4'h0});
      dc_cnt = 8'h00;
      tick(400);
      check("dclk rises", near(dc_cnt, div_exp[c]), div_exp[c]);
    end
    $display("divider test done");
    // Data clock delay: the enable gates the code and the msb extends it
    wr(ADDR_DDLY, 8'h30);
    wr(ADDR_DIGCTL_A, 8'h00);
    @(posedge ref_clk);
    tick(5);
    check("dclk phase", {7'h0, dclk}, 8'h01);
    wr(ADDR_DIGCTL_B, 8'h10);
    @(posedge ref_clk);
    tick(5);
    check("dclk phase", {7'h0, dclk}, 8'h00);
    tick(3);
    check("dclk phase", {7'h0, dclk}, 8'h01);
    wr(ADDR_DDLY, 8'h00);
    wr(ADDR_DIGCTL_A, 8'h02);
    @(posedge ref_clk);
    tick(1);
    check("dclk phase", {7'h0, dclk}, 8'h01);
    $display("delay test done");
    // Margin thresholds, automatic then manual checking
    wr(ADDR_CFG, 8'hC5);
    margin(4'h5, 1'b0, 4'hF);
    check("data err", {7'h0, dterr}, 8'h00);
    margin(4'h4, 1'b0, 4'hF);
    check("data err", {7'h0, dterr}, 8'h01);
    wr(ADDR_CFG, 8'h45);
    check("data err", {7'h0, dterr}, 8'h00);
    margin(4'h4, 1'b0, 4'hF);
    check("data err", {7'h0, dterr}, 8'h00);
    margin(4'h4, 1'b1, 4'hF);
    check("data err", {7'h0, dterr}, 8'h01);
    wr(ADDR_SIDLY, 8'h03);
    margin(4'hF, 1'b0, 4'h3);
    check("sync err", {7'h0, sterr}, 8'h00);
    margin(4'hF, 1'b0, 4'h2);
    check("sync err", {7'h0, sterr}, 8'h01);
    $display("margin test done");
    // Sync input: refused while disabled, then counted by ratio
    wr(ADDR_SEN, 8'h15);
    wr(ADDR_SODLY, 8'h02);
    wr(ADDR_SIDLY, 8'h00);
    u_peer.send(2);
    tick(30);
    check("sync pulses", sp_cnt, 8'h00);
    wr(ADDR_SEN, 8'h95);
    u_peer.send(1);
    tick(30);
    check("sync pulses", sp_cnt, 8'h00);
    u_peer.send(1);
    tick(30);
    check("sync pulses", sp_cnt, 8'h01);
    check("clock state", {3'h0, st_cap}, 8'h15);
    check("sync out", u_peer.so_cnt, 8'h00);
    $display("sync input test done");
    // Sync output rate for N = 32 and N = 1, both launch edges
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_DDLY, 8'h00);
      wr(ADDR_SEN, {2'h3, e[0], 5'h05});
      u_peer.so_cnt = 8'h00;
      tick(640);
      check("sync out", near(u_peer.so_cnt, 8'h14), 8'h14);
      wr(ADDR_DDLY, 8'h0A);
      u_peer.so_cnt = 8'h00;
      tick(640);
      check("sync out", near(u_peer.so_cnt, 8'h20), 8'h20);
      // Launch phase: the pulse follows only the selected reference edge
      @(posedge ref_clk);
      tick(5);
      check("sync edge", {7'h0, sync_out}, {7'h0, e[0]});
      @(negedge ref_clk);
      tick(5);
      check("sync edge", {7'h0, sync_out}, {7'h0, ~e[0]});
    end
    // Sync output delay of three steps moves the pulse three clocks later
    wr(ADDR_SODLY, 8'h32);
    @(posedge ref_clk);
    tick(5);
    check("sync delay", {7'h0, sync_out}, 8'h00);
    tick(3);
    check("sync delay", {7'h0, sync_out}, 8'h01);
    wr(ADDR_SEN, 8'h95);
    u_peer.so_cnt = 8'h00;
    tick(200);
    check("sync out", u_peer.so_cnt, 8'h00);
    $display("sync output test done");
    complete_run();
  end
endmodule

`default_nettype wire
